// *** lbp_port_blink_pwm.sv ***
`timescale 1ns/1ps

module lbp_port_blink_pwm #(
    parameter int MS_CYCLES       = lbp_pkg::MS_CYCLES,
    parameter int PWM_STEP_CYCLES = lbp_pkg::PWM_STEP_CYCLES
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_srst,
    // register writes from the serial host interface
    input  wire lbp_pkg::lbp_wr_s      i_cfg_wr,
    input  wire lbp_pkg::lbp_wr_s      i_pwm_wr,
    // shared intensity from the fade logic
    input  wire logic [7:0]            i_common_pwm,
    // port state
    input  wire logic [7:0]            i_port_is_input,
    input  wire logic [7:0]            i_port_in,
    input  wire logic                  i_rotary_mode,
    // outputs
    output logic [7:0]                 o_port_drive,
    output logic [7:0]                 o_port_irq,
    output logic                       o_port_input_irq_out
);

    if (MS_CYCLES < 2 || PWM_STEP_CYCLES < 1)
    begin : g_bad_param
        $error("lbp_port_blink_pwm: timing parameters out of range");
    end

    // port vectors are fixed at eight bits
    if (lbp_pkg::NUM_PORTS != 8 || lbp_pkg::ROTARY_PORT >= lbp_pkg::NUM_PORTS)
    begin : g_bad_ports
        $error("lbp_port_blink_pwm: port layout out of range");
    end

    // one shared ms counter only serves if it wraps at the longest period
    if (lbp_pkg::BLINK_BASE_LOG2 + 32'(lbp_pkg::BLINK_MAX_CODE) != lbp_pkg::MS_BITS)
    begin : g_bad_wrap
        $error("lbp_port_blink_pwm: blink counter width out of range");
    end

    localparam int MS_W  = $clog2(MS_CYCLES);
    localparam int PWM_W = (PWM_STEP_CYCLES > 1) ? $clog2(PWM_STEP_CYCLES) : 1;
    localparam logic [MS_W-1:0]  MS_LAST  = MS_W'(MS_CYCLES - 1);
    localparam logic [PWM_W-1:0] PWM_LAST = PWM_W'(PWM_STEP_CYCLES - 1);

    // blink window test; all periods divide the 4096 ms wrap so one counter serves all
    function automatic logic blink_gate(input lbp_pkg::lbp_cfg_s cfg,
                                        input logic [lbp_pkg::MS_BITS-1:0] ms);
        int unsigned               lg;
        logic [lbp_pkg::MS_BITS:0] mask;
        logic [lbp_pkg::MS_BITS:0] win;
        lg   = 0;
        mask = '0;
        win  = '0;
        if (cfg.blink_period == lbp_pkg::BLINK_OFF)
            blink_gate = 1'b1;
        else if (cfg.blink_period > lbp_pkg::BLINK_MAX_CODE)
            blink_gate = 1'b0; // undefined codes held dark
        else
        begin
            lg   = lbp_pkg::BLINK_BASE_LOG2 + 32'(cfg.blink_period);
            mask = (lbp_pkg::MS_BITS+1)'((1 << lg) - 1);
            win  = (lbp_pkg::MS_BITS+1)'(1 << (lg - 1 - 32'(cfg.blink_on)));
            blink_gate = (({1'b0, ms} & mask) < win);
        end
    endfunction

    lbp_pkg::lbp_cfg_s  cfg_reg  [lbp_pkg::NUM_PORTS];
    lbp_pkg::lbp_cfg_s  cfg_next [lbp_pkg::NUM_PORTS];
    logic [7:0]         pwm_reg  [lbp_pkg::NUM_PORTS];
    logic [7:0]         pwm_next [lbp_pkg::NUM_PORTS];

    logic [MS_W-1:0]                 div_reg,   div_next;
    logic [lbp_pkg::MS_BITS-1:0]     ms_reg,    ms_next;
    logic [PWM_W-1:0]                pdiv_reg,  pdiv_next;
    logic [7:0]                      pcnt_reg,  pcnt_next;
    logic                            ms_tick;
    logic                            pwm_tick;
    logic [7:0]                      prev_reg,  prev_next;
    logic [7:0]                      drive_reg, drive_next;
    logic [7:0]                      irq_reg,   irq_next;
    logic                            any_reg,   any_next;

    // register file
    // a write lands at the edge that samples its strobe; no readback path
    always_comb
    begin
        for (int p = 0; p < lbp_pkg::NUM_PORTS; p++)
        begin
            cfg_next[p] = cfg_reg[p];
            pwm_next[p] = pwm_reg[p];
        end
        if (i_cfg_wr.we)
            cfg_next[i_cfg_wr.sel] = lbp_pkg::lbp_cfg_s'(i_cfg_wr.data);
        if (i_pwm_wr.we)
            pwm_next[i_pwm_wr.sel] = i_pwm_wr.data;
    end

    always_ff @(posedge i_ref_clk)
    begin
        for (int p = 0; p < lbp_pkg::NUM_PORTS; p++)
        begin
            if (i_srst)
            begin
                cfg_reg[p] <= lbp_pkg::lbp_cfg_s'(lbp_pkg::CFG_RESET);
                pwm_reg[p] <= lbp_pkg::PWM_RESET;
            end
            else
            begin
                cfg_reg[p] <= cfg_next[p];
                pwm_reg[p] <= pwm_next[p];
            end
        end
    end

    // time bases: millisecond tick for blink, step tick for pwm
    // both are one-cycle enables from dividers; nothing runs on a derived clock
    always_comb
    begin
        ms_tick   = (div_reg == MS_LAST);
        pwm_tick  = (pdiv_reg == PWM_LAST);
        div_next  = ms_tick ? '0 : div_reg + 1'b1;
        ms_next   = ms_tick ? ms_reg + 1'b1 : ms_reg;
        pdiv_next = pwm_tick ? '0 : pdiv_reg + 1'b1;
        pcnt_next = pwm_tick ? pcnt_reg + 1'b1 : pcnt_reg;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            div_reg  <= '0;
            ms_reg   <= '0;
            pdiv_reg <= '0;
            pcnt_reg <= '0;
        end
        else
        begin
            div_reg  <= div_next;
            ms_reg   <= ms_next;
            pdiv_reg <= pdiv_next;
            pcnt_reg <= pcnt_next;
        end
    end

    // drive logic, registered so a counter carry never glitches the pin
    always_comb
    begin
        logic [7:0] duty;
        duty       = '0;
        drive_next = '0;
        for (int p = 0; p < lbp_pkg::NUM_PORTS; p++)
        begin
            duty = cfg_reg[p].use_common ? i_common_pwm : pwm_reg[p];
            // all-ones is full on, so 255/256 is never produced
            drive_next[p] = ((duty == lbp_pkg::PWM_FULL) || (pcnt_reg < duty))
                          && blink_gate(cfg_reg[p], ms_reg);
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            drive_reg <= '0;
        end
        else
        begin
            drive_reg <= drive_next;
        end
    end

    // interrupt logic
    always_comb
    begin
        logic rise;
        logic fall;
        logic masked;
        rise      = 1'b0;
        fall      = 1'b0;
        masked    = 1'b0;
        irq_next  = '0;
        any_next  = 1'b0;
        prev_next = i_port_in;
        for (int p = 0; p < lbp_pkg::NUM_PORTS; p++)
        begin
            rise = i_port_in[p] & ~prev_reg[p];
            fall = ~i_port_in[p] & prev_reg[p];
            irq_next[p] = i_port_is_input[p]
                        && (rise || (cfg_reg[p].both_edges && fall));
            masked = cfg_reg[p].irq_mask
                   && !(p == lbp_pkg::ROTARY_PORT && i_rotary_mode);
            if (irq_next[p] && !masked)
                any_next = 1'b1;
        end
    end

    // pin history follows the pins through reset: pins idling high give no false edge
    always_ff @(posedge i_ref_clk)
    begin
        prev_reg <= prev_next;
        if (i_srst)
        begin
            irq_reg <= '0;
            any_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_next;
            any_reg <= any_next;
        end
    end

    assign o_port_drive         = drive_reg;
    assign o_port_irq           = irq_reg;
    assign o_port_input_irq_out = any_reg;

endmodule

// *** lbp_pkg.sv ***
package lbp_pkg;

    // per-port configuration layout, msb first
    typedef struct packed {
        logic       irq_mask;
        logic       both_edges;
        logic       use_common;
        logic [2:0] blink_period;
        logic [1:0] blink_on;
    } lbp_cfg_s;

    // one write strobe with its target port and data
    typedef struct packed {
        logic       we;
        logic [2:0] sel;
        logic [7:0] data;
    } lbp_wr_s;

    localparam int          NUM_PORTS       = 8;
    localparam int          ROTARY_PORT     = 7;
    localparam logic [7:0]  CFG_RESET       = 8'h00;
    localparam logic [7:0]  PWM_RESET       = 8'h00;
    localparam logic [7:0]  PWM_FULL        = 8'hff;
    localparam logic [2:0]  BLINK_OFF       = 3'h0;
    localparam logic [2:0]  BLINK_MAX_CODE  = 3'h5;
    localparam int          BLINK_BASE_LOG2 = 7;
    localparam int          MS_BITS         = 12;
    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          MS_NS           = 1000000;
    localparam int          MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
    localparam int          PWM_STEP_CYCLES = 8;

endpackage

// *** lbp_props.sv ***
`timescale 1ns/1ps
module lbp_props (
    input wire logic             i_ref_clk,
    input wire logic             i_srst,
    input wire lbp_pkg::lbp_wr_s i_cfg_wr,
    input wire logic [7:0]       i_common_pwm,
    input wire logic [7:0]       i_port_is_input,
    input wire logic [7:0]       i_port_in,
    input wire logic             i_rotary_mode,
    input wire logic [7:0]       o_port_drive,
    input wire logic [7:0]       o_port_irq,
    input wire logic             o_port_input_irq_out
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    logic [7:0]        prev_reg;
    lbp_pkg::lbp_cfg_s cfg0_reg;
    wire  [7:0]        rises = i_port_is_input & i_port_in & ~prev_reg;
    // port 0 shadow only, to keep the checker small
    always_ff @(posedge i_ref_clk)
    begin
        prev_reg <= i_port_in;
        if (i_srst)
            cfg0_reg <= '0;
        else if (i_cfg_wr.we && i_cfg_wr.sel == 3'h0)
            cfg0_reg <= i_cfg_wr.data;
    end
    chk_irq_input_only: assert property (
        (o_port_irq & ~$past(i_port_is_input)) == 8'h00) else $error("irq on output port");
    chk_rise_irq: assert property (
        rises != 8'h00 |=> (o_port_irq & $past(rises)) == $past(rises)) else $error("rise lost");
    chk_irq_needs_change: assert property (
        (o_port_irq & ~$past(i_port_in ^ prev_reg)) == 8'h00) else $error("irq without edge");
    chk_agg_from_port: assert property (
        o_port_input_irq_out |-> o_port_irq != 8'h00) else $error("stray summary irq");
    chk_rotary_unmask: assert property (
        $past(i_rotary_mode) && o_port_irq[7] |-> o_port_input_irq_out) else $error("rotary masked");
    chk_zero_duty: assert property (
        $fell(i_srst) |-> ##1 o_port_drive == 8'h00) else $error("drive after reset");
    chk_common_full: assert property (
        cfg0_reg.use_common && cfg0_reg.blink_period == 3'h0 && i_common_pwm == 8'hff
        |=> o_port_drive[0]) else $error("common full not on");
endmodule

bind lbp_port_blink_pwm lbp_props lbp_props_i (
    .i_ref_clk            (i_ref_clk),
    .i_srst               (i_srst),
    .i_cfg_wr             (i_cfg_wr),
    .i_common_pwm         (i_common_pwm),
    .i_port_is_input      (i_port_is_input),
    .i_port_in            (i_port_in),
    .i_rotary_mode        (i_rotary_mode),
    .o_port_drive         (o_port_drive),
    .o_port_irq           (o_port_irq),
    .o_port_input_irq_out (o_port_input_irq_out)
);

// *** lbp_host.sv ***
`timescale 1ns/1ps
module lbp_host (
    input  wire logic        i_ref_clk,
    output lbp_pkg::lbp_wr_s o_cfg_wr,
    output lbp_pkg::lbp_wr_s o_pwm_wr
);
    initial {o_cfg_wr, o_pwm_wr} = '0;
    task automatic wr(input bit pwm, input logic [2:0] sel, input logic [7:0] d);
        lbp_pkg::lbp_wr_s w;
        w = '{1'b1, sel, d};
        // undefined blink codes never leave the host
        if (!pwm && d[4:2] > lbp_pkg::BLINK_MAX_CODE) w.data[4:2] = lbp_pkg::BLINK_OFF;
        @(posedge i_ref_clk);
        if (pwm) o_pwm_wr <= w;
        else o_cfg_wr <= w;
        @(posedge i_ref_clk);
        o_pwm_wr.we <= 1'b0;
        o_cfg_wr.we <= 1'b0;
    endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    logic             i_ref_clk = 1'b0, i_srst = 1'b1, i_rotary_mode = 1'b0;
    logic [7:0]       i_common_pwm = 8'h00, i_port_is_input = 8'h88, i_port_in = 8'h00;
    lbp_pkg::lbp_wr_s i_cfg_wr, i_pwm_wr;
    logic [7:0]       o_port_drive, o_port_irq;
    logic             o_port_input_irq_out;
    int               fail_count = 0, checks_done = 0, cyc = 0;
    integer           n;
    initial forever #10 i_ref_clk = ~i_ref_clk;
    lbp_host lbp_host_i (.i_ref_clk(i_ref_clk), .o_cfg_wr(i_cfg_wr), .o_pwm_wr(i_pwm_wr));
    lbp_port_blink_pwm #(.MS_CYCLES(4), .PWM_STEP_CYCLES(1)) lbp_port_blink_pwm_i (
        .i_ref_clk            (i_ref_clk),
        .i_srst               (i_srst),
        .i_cfg_wr             (i_cfg_wr),
        .i_pwm_wr             (i_pwm_wr),
        .i_common_pwm         (i_common_pwm),
        .i_port_is_input      (i_port_is_input),
        .i_port_in            (i_port_in),
        .i_rotary_mode        (i_rotary_mode),
        .o_port_drive         (o_port_drive),
        .o_port_irq           (o_port_irq),
        .o_port_input_irq_out (o_port_input_irq_out)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic step_in(input logic [7:0] v);
        @(posedge i_ref_clk);
        i_port_in <= v;
        @(posedge i_ref_clk);
        #1;
    endtask
    // settle first: drive lags a write by two edges
    task automatic count(input int p, input int len);
        repeat (3) @(posedge i_ref_clk);
        n = 0;
        // sampled mid-cycle where the registered drive has settled
        repeat (len)
        begin
            @(negedge i_ref_clk);
            n += o_port_drive[p];
        end
        @(posedge i_ref_clk);
    endtask
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc > 70000)
        begin
            fail_count++;
            final_report();
        end
    end
    initial
    begin
        repeat (2) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        step_in(8'h18);
        chk({o_port_irq, o_port_input_irq_out}, 9'h011);
        step_in(8'h00);
        chk({o_port_irq, o_port_input_irq_out}, 9'h000);
        lbp_host_i.wr(0, 3'h3, 8'hc0);
        step_in(8'h08);
        chk({o_port_irq, o_port_input_irq_out}, 9'h010);
        step_in(8'h00);
        chk(o_port_irq, 8'h08);
        lbp_host_i.wr(0, 3'h7, 8'h80);
        i_rotary_mode <= 1'b1;
        step_in(8'h80);
        chk({o_port_irq, o_port_input_irq_out}, 9'h101);
        lbp_host_i.wr(1, 3'h1, 8'h80);
        count(1, 256);
        chk(n, 128);
        count(2, 256);
        chk(n, 0);
        lbp_host_i.wr(0, 3'h0, 8'h20);
        i_common_pwm <= 8'hff;
        count(0, 8);
        chk(n, 8);
        i_common_pwm <= 8'h40;
        count(0, 256);
        chk(n, 64);
        lbp_host_i.wr(1, 3'h5, 8'hff);
        // the two longest periods get one on-time each to bound run time
        for (int p = 1; p < 6; p++)
            for (int o = 0; o < 4; o++)
                if (p < 4 || o == p - 3)
                begin
                    lbp_host_i.wr(0, 3'h5, {3'h0, p[2:0], o[1:0]});
                    count(5, 512 << p);
                    chk(n, (512 << p) >> (1 + o));
                end
        lbp_host_i.wr(0, 3'h5, 8'h00);
        count(5, 64);
        chk(n, 64);
        // mid-run reset with port 7 held high: no false edge, intensities back to zero
        i_srst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        chk({o_port_irq, o_port_input_irq_out}, 9'h000);
        count(5, 64);
        chk(n, 0);
        final_report();
    end
endmodule
